// ### hw/eppecp_fifo.sv
`timescale 1ns/1ps
module eppecp_fifo (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         push,
   input  wire logic [eppecp_pkg::PWORD_W-1:0] push_data,
   input  wire logic                         pop,
   output logic      [eppecp_pkg::PWORD_W-1:0] head,
   output logic                              full,
   output logic                              empty
);
   import eppecp_pkg::*;

   logic [PWORD_W-1:0] mem [FIFO_DEPTH];
   logic [FIFO_AW-1:0] wp_q;
   logic [FIFO_AW-1:0] rp_q;
   logic [FIFO_AW:0]   cnt_q;
   logic               do_push;
   logic               do_pop;

   assign full    = (cnt_q == (FIFO_AW+1)'(FIFO_DEPTH));
   assign empty   = (cnt_q == '0);
   assign do_push = push & ~full;  // Pushes into a full FIFO are dropped
   assign do_pop  = pop & ~empty;
   assign head    = mem[rp_q];

   // Storage written without reset; only the pointers and count need a defined value
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wp_q] <= push_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (do_pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (FIFO_AW+1)'(do_push) - (FIFO_AW+1)'(do_pop);
      end
   end

   property p_no_overflow;
      @(posedge clk) disable iff (rst)
      full && push && !pop |=> full;
   endproperty
   a_no_overflow: assert property (p_no_overflow) else $error("fifo count moved past full");

   property p_full_flag;
      @(posedge clk) disable iff (rst)
      (cnt_q == (FIFO_AW+1)'(FIFO_DEPTH - 1)) && push && !pop |=> full && !empty;
   endproperty
   a_full_flag: assert property (p_full_flag) else $error("full not set at sixteen");
endmodule // eppecp_fifo

// ### hw/eppecp_pkg.sv
package eppecp_pkg;

   // Port word and shared FIFO geometry
   localparam int PWORD_W    = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW    = 4;
   localparam int ADDR_W     = 11;

   // Clock and cycle watchdog
   localparam int CLK_MHZ     = 50;
   localparam int EPP_TMO_US  = 10;
   localparam int EPP_TMO_CYC = EPP_TMO_US * CLK_MHZ;
   localparam int TMR_W       = 10;

   // Register offsets from the port base
   localparam logic [ADDR_W-1:0] OFS_DATA     = 11'h000;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 11'h001;
   localparam logic [ADDR_W-1:0] OFS_CONTROL  = 11'h002;
   localparam logic [ADDR_W-1:0] OFS_EPP_ADDR = 11'h003;
   localparam logic [ADDR_W-1:0] OFS_EPP_DAT0 = 11'h004;
   localparam logic [ADDR_W-1:0] OFS_EPP_DAT3 = 11'h007;
   localparam logic [ADDR_W-1:0] OFS_FIFO     = 11'h400;
   localparam logic [ADDR_W-1:0] OFS_CONFIG_B_IRQ_DMA    = 11'h401;
   localparam logic [ADDR_W-1:0] OFS_ECR      = 11'h402;

   // Port modes held in the extended control register
   localparam logic [2:0] MODE_SPP  = 3'h0;
   localparam logic [2:0] MODE_PS2  = 3'h1;
   localparam logic [2:0] MODE_CFIF = 3'h2;
   localparam logic [2:0] MODE_ECP  = 3'h3;
   localparam logic [2:0] MODE_EPP  = 3'h4;
   localparam logic [2:0] MODE_TEST = 3'h6;
   localparam logic [2:0] MODE_CFG  = 3'h7;

   // Control register fields
   localparam int DCR_STROBE = 0;
   localparam int DCR_NINIT  = 2;
   localparam int DCR_ACKIEN = 4;
   localparam int DCR_DIR    = 5;
   localparam logic [5:0] DCR_RST = 6'h04;

   // Status and extended control fields
   localparam int DSR_TMO = 0;
   localparam logic [PWORD_W-1:0] CONFIG_A_FIXED_VAL = 8'h10;
   localparam logic [4:0] ECR_RST = 5'h00;

   // One-hot cycle states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_ACTIVE = 3'b010,
      ST_ABORT  = 3'b100
   } eppecp_state_t;

endpackage

// ### hw/eppecp_port.sv
`timescale 1ns/1ps
// How it works
// - Read strobe raises data or address strobe
// - Wait holds ready low until release/timeout
// - Ten microsecond watchdog aborts, sets status bit0
// - Host strobe removal drops port strobe
// - Write indication low for writes, or for the control strobe bit with direction clear
// - Interrupt input passes through, active high
// - Separate active-low data and address strobes
// - Active-low peripheral reset output
// - Direction high on direction bit or read
// - Write indication, direction and reset all follow control port
// - Standard and enhanced share data latch
// - Port word is eight bits
// - Data reads, status, control reachable in all modes; data writes in all but ECP mode
// - All FIFO ports share one 16-byte FIFO
// - Config B reports selected IRQ, DMA
module eppecp_port (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic                            isa_cs,
   input  wire logic [eppecp_pkg::ADDR_W-1:0]   isa_addr,
   input  wire logic                            isa_ior_n,
   input  wire logic                            isa_iow_n,
   input  wire logic [eppecp_pkg::PWORD_W-1:0]  isa_data_in,
   output logic      [eppecp_pkg::PWORD_W-1:0]  isa_data_out,
   output logic                                 isa_data_oe,
   output logic                                 isa_iochrdy,
   input  wire logic [2:0]                      cfg_irq_sel,
   input  wire logic [2:0]                      cfg_dma_sel,
   input  wire logic [eppecp_pkg::PWORD_W-1:0]  parallel_data_bus_in,
   output logic      [eppecp_pkg::PWORD_W-1:0]  parallel_data_bus_out,
   output logic                                 parallel_data_bus_oe,
   input  wire logic                            peripheral_wait_n,
   input  wire logic                            peripheral_interrupt_in,
   input  wire logic                            ack_n,
   input  wire logic                            paper_error,
   input  wire logic                            select_in,
   input  wire logic                            fault_n,
   output logic                                 data_strobe_n,
   output logic                                 address_strobe_n,
   output logic                                 write_indication_n,
   output logic                                 port_direction_out,
   output logic                                 peripheral_reset_n,
   output logic                                 port_irq
);
   import eppecp_pkg::*;

   logic [15:0]        pins_s;
   logic               ior_n_s;
   logic               iow_n_s;
   logic               wait_n_s;
   logic               peripheral_interrupt_in_s;
   logic               ack_n_s;
   logic               perr_s;
   logic               sel_s;
   logic               fault_n_s;
   logic [PWORD_W-1:0] pd_s;
   logic               rd_q;
   logic               wr_q;
   logic               rd_start;
   logic               wr_start;
   logic               cyc_req;
   logic               epp_sel;
   logic               fifo_sel;
   eppecp_state_t      state_q;
   logic [TMR_W-1:0]   tmr_q;
   logic               cyc_rd_q;
   logic               tmo_q;
   logic [PWORD_W-1:0] data_latch_q;
   logic [5:0]         dcr_q;
   logic [4:0]         ecr_q;
   logic [PWORD_W-1:0] rd_mux;
   logic               fifo_push;
   logic               fifo_pop;
   logic [PWORD_W-1:0] fifo_head;
   logic               fifo_full;
   logic               fifo_empty;
   logic               peripheral_interrupt_in_q;

   // Host strobes and every peripheral pin cross into clk here
   eppecp_sync #(.W(16), .RST_VAL(16'hEF00)) u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in ({isa_ior_n, isa_iow_n, peripheral_wait_n, peripheral_interrupt_in,
                  ack_n, paper_error, select_in, fault_n, parallel_data_bus_in}),
      .sync_out (pins_s)
   );
   assign {ior_n_s, iow_n_s, wait_n_s, peripheral_interrupt_in_s, ack_n_s, perr_s, sel_s, fault_n_s} = pins_s[15:8];
   assign pd_s = pins_s[7:0];

   // Strobe history for start edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         rd_q <= ~ior_n_s & isa_cs;
         wr_q <= ~iow_n_s & isa_cs;
      end
   end

   // Address decode; enhanced ports answer only in their own mode
   assign rd_start = ~ior_n_s & isa_cs & ~rd_q;
   assign wr_start = ~iow_n_s & isa_cs & ~wr_q;
   assign cyc_req  = ~ior_n_s | ~iow_n_s;
   assign epp_sel  = (ecr_q[4:2] == MODE_EPP) && (isa_addr >= OFS_EPP_ADDR)
                     && (isa_addr <= OFS_EPP_DAT3);
   assign fifo_sel = (isa_addr == OFS_FIFO);

   // Enhanced cycle sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q  <= ST_IDLE;
         cyc_rd_q <= 1'b0;
         tmr_q    <= '0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               tmr_q <= '0;
               if ((rd_start | wr_start) && epp_sel) begin
                  state_q  <= ST_ACTIVE;
                  cyc_rd_q <= rd_start;
               end
            end
            ST_ACTIVE: begin
               tmr_q <= tmr_q + 1'b1;
               if (!cyc_req) begin
                  state_q <= ST_IDLE;
               end else if (tmr_q == TMR_W'(EPP_TMO_CYC - 1)) begin
                  state_q <= ST_ABORT;
               end
            end
            ST_ABORT: begin
               // Held off until the host lets go, so one timeout gives one abort
               if (!cyc_req) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_strobe_n    <= 1'b1;
         address_strobe_n <= 1'b1;
      end else begin
         data_strobe_n    <= 1'b1;
         address_strobe_n <= 1'b1;
         if (state_q == ST_IDLE && (rd_start | wr_start) && epp_sel) begin
            data_strobe_n    <= (isa_addr == OFS_EPP_ADDR);
            address_strobe_n <= (isa_addr != OFS_EPP_ADDR);
         end else if (state_q == ST_ACTIVE && cyc_req
                      && tmr_q != TMR_W'(EPP_TMO_CYC - 1)) begin
            data_strobe_n    <= data_strobe_n;
            address_strobe_n <= address_strobe_n;
         end
      end
   end

   // ready held low while the peripheral waits
   assign isa_iochrdy = !(state_q == ST_ACTIVE && !wait_n_s);

   // timeout flag; a new timeout beats the clearing status read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tmo_q <= 1'b0;
      end else if (state_q == ST_ACTIVE && cyc_req && tmr_q == TMR_W'(EPP_TMO_CYC - 1)) begin
         tmo_q <= 1'b1;
      end else if (rd_start && isa_addr == OFS_STATUS) begin
         tmo_q <= 1'b0;
      end
   end

   // one data latch serves standard and enhanced writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_latch_q <= '0;
      end else if (wr_start && ((isa_addr == OFS_DATA && ecr_q[4:2] != MODE_ECP)
                                || (epp_sel && isa_addr != OFS_EPP_ADDR))) begin
         data_latch_q <= isa_data_in;
      end
   end

   // control and extended control writes, any mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dcr_q <= DCR_RST;
         ecr_q <= ECR_RST;
      end else if (wr_start) begin
         if (isa_addr == OFS_CONTROL) begin
            dcr_q <= isa_data_in[5:0];
         end
         if (isa_addr == OFS_ECR) begin
            ecr_q <= isa_data_in[7:3];
         end
      end
   end

   // every FIFO address lands in the one shared FIFO
   assign fifo_push = wr_start && (
         (isa_addr == OFS_DATA && ecr_q[4:2] == MODE_ECP)
      || (fifo_sel && (ecr_q[4:2] == MODE_CFIF || ecr_q[4:2] == MODE_ECP
                       || ecr_q[4:2] == MODE_TEST)));
   assign fifo_pop = rd_start && fifo_sel
                     && (ecr_q[4:2] == MODE_ECP || ecr_q[4:2] == MODE_TEST);

   eppecp_fifo u_fifo (
      .clk       (clk),
      .rst       (rst),
      .push      (fifo_push),
      .push_data (isa_data_in),
      .pop       (fifo_pop),
      .head      (fifo_head),
      .full      (fifo_full),
      .empty     (fifo_empty)
   );

   // Read mux; config B shows the selected IRQ and DMA
   always_comb begin
      rd_mux = '0;
      unique case (isa_addr)
         OFS_DATA:    rd_mux = data_latch_q;
         OFS_STATUS:  rd_mux = {wait_n_s, ack_n_s, perr_s, sel_s, fault_n_s, 2'b00, tmo_q};
         OFS_CONTROL: rd_mux = {2'b00, dcr_q};
         OFS_FIFO:    rd_mux = (ecr_q[4:2] == MODE_CFG) ? CONFIG_A_FIXED_VAL : fifo_head;
         OFS_CONFIG_B_IRQ_DMA:   rd_mux = {1'b0, peripheral_interrupt_in_s, cfg_irq_sel, cfg_dma_sel};
         // full and empty in the low bits
         OFS_ECR:     rd_mux = {ecr_q, 1'b0, fifo_full, fifo_empty};  // Service bit reads 0: no irq logic
         default:     rd_mux = '0;
      endcase
   end

   // Read data; during an enhanced read it follows the peripheral bus
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         isa_data_out <= '0;
      end else if (state_q == ST_ACTIVE && cyc_rd_q) begin
         isa_data_out <= pd_s;
      end else if (rd_start) begin
         isa_data_out <= rd_mux;
      end
   end
   assign isa_data_oe = rd_q;

   // direction high for the control bit or an enhanced read
   assign port_direction_out = dcr_q[DCR_DIR] | (state_q != ST_IDLE && cyc_rd_q);
   assign parallel_data_bus_out = data_latch_q;
   assign parallel_data_bus_oe  = ~port_direction_out;

   // write indication; control port overrides it
   assign write_indication_n = ~((state_q == ST_ACTIVE && !cyc_rd_q)
                                 || (!dcr_q[DCR_DIR] && dcr_q[DCR_STROBE]));

   // peripheral reset from the control register
   assign peripheral_reset_n = dcr_q[DCR_NINIT];

   // interrupt passes through, gated by its enable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         peripheral_interrupt_in_q <= 1'b0;
      end else begin
         peripheral_interrupt_in_q <= peripheral_interrupt_in_s & dcr_q[DCR_ACKIEN];
      end
   end
   assign port_irq = peripheral_interrupt_in_q;

   property p_strobe_start;
      @(posedge clk) disable iff (rst)
      state_q == ST_IDLE && rd_start && epp_sel |=> !data_strobe_n || !address_strobe_n;
   endproperty
   a_strobe_start: assert property (p_strobe_start) else $error("no strobe after read");

   property p_ready_hold;
      @(posedge clk) disable iff (rst)
      state_q == ST_ACTIVE && !wait_n_s |-> !isa_iochrdy;
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready released while wait");

   property p_timeout;
      @(posedge clk) disable iff (rst)
      state_q == ST_ACTIVE && cyc_req && tmr_q == TMR_W'(EPP_TMO_CYC - 1)
      |=> tmo_q && data_strobe_n && address_strobe_n && isa_iochrdy;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout did not abort");

   property p_strobe_end;
      @(posedge clk) disable iff (rst)
      state_q == ST_ACTIVE && !cyc_req |=> data_strobe_n && address_strobe_n && state_q == ST_IDLE;
   endproperty
   a_strobe_end: assert property (p_strobe_end) else $error("strobe kept after host end");

   property p_one_strobe;
      @(posedge clk) disable iff (rst)
      !(data_strobe_n == 1'b0 && address_strobe_n == 1'b0);
   endproperty
   a_one_strobe: assert property (p_one_strobe) else $error("both strobes active");

   property p_read_dir;
      @(posedge clk) disable iff (rst)
      state_q == ST_ACTIVE && cyc_rd_q |-> port_direction_out && write_indication_n != 1'b0 || dcr_q[DCR_STROBE];
   endproperty
   a_read_dir: assert property (p_read_dir) else $error("read cycle not input");

   property p_irq_pass;
      @(posedge clk) disable iff (rst)
      $rose(peripheral_interrupt_in_s) && dcr_q[DCR_ACKIEN] ##1 dcr_q[DCR_ACKIEN] |-> port_irq;
   endproperty
   a_irq_pass: assert property (p_irq_pass) else $error("interrupt not passed");

   property p_reset_out;
      @(posedge clk) disable iff (rst)
      wr_start && isa_addr == OFS_CONTROL && !isa_data_in[DCR_NINIT] |=> !peripheral_reset_n;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("peripheral reset not driven");
endmodule // eppecp_port

// ### hw/eppecp_sync.sv
`timescale 1ns/1ps
module eppecp_sync #(
   parameter int          W       = 1,
   parameter logic [15:0] RST_VAL = 16'h0000
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // Three stages; a bit changes only once stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q     <= RST_VAL[W-1:0];
         s2_q     <= RST_VAL[W-1:0];
         s3_q     <= RST_VAL[W-1:0];
         sync_out <= RST_VAL[W-1:0];
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               sync_out[i] <= s3_q[i];
            end
         end
      end
   end
endmodule // eppecp_sync

// ### test/eppecp_periph.sv
`timescale 1ns/1ps
// Behavioural enhanced-port peripheral that answers strobes
module eppecp_periph (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       data_strobe_n,
   input  wire logic       address_strobe_n,
   input  wire logic       write_indication_n,
   input  wire logic [7:0] bus_out,
   input  wire logic       bus_oe,
   input  wire logic       stall,
   input  wire logic [3:0] lag,
   input  wire logic [7:0] rd_val,
   input  wire logic       irq_req,
   output logic            peripheral_wait_n,
   output logic      [7:0] bus_in,
   output logic            peripheral_interrupt_in
);
   logic       drv_q;
   logic [3:0] cnt_q;
   logic [7:0] last_q;
   wire        stb = ~(data_strobe_n & address_strobe_n);

   assign peripheral_interrupt_in = irq_req;

   // wire level; a floated bus shows a changing pattern, never stale data
   assign bus_in = bus_oe ? bus_out : (drv_q ? rd_val : ~last_q);

   // data before wait release, float and re-arm wait once strobe drops
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         drv_q <= 1'b0;
         cnt_q <= 4'h0;
         last_q <= 8'h00;
         peripheral_wait_n <= 1'b0;
      end else begin
         last_q <= bus_in;
         if (!stb) begin
            drv_q <= 1'b0;
            cnt_q <= 4'h0;
            peripheral_wait_n <= 1'b0;
         end else if (!stall && !peripheral_wait_n) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == lag) drv_q <= write_indication_n;
            if (cnt_q == lag + 4'h3) peripheral_wait_n <= 1'b1;
         end
      end
   end
endmodule // eppecp_periph

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
   import eppecp_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, isa_cs = 1'b0, isa_ior_n = 1'b1, isa_iow_n = 1'b1;
   logic [10:0] isa_addr = 11'h000;
   logic [7:0]  isa_data_in = 8'h00, isa_data_out, bus_in, bus_out, rd_val = 8'h00, q;
   logic [2:0]  cfg_irq_sel = 3'h5, cfg_dma_sel = 3'h3;
   logic        ack_n = 1'b0, paper_error = 1'b1, select_in = 1'b1, fault_n = 1'b0;
   logic        isa_data_oe, isa_iochrdy, bus_oe, peripheral_wait_n, peripheral_interrupt_in;
   logic        data_strobe_n, address_strobe_n, write_indication_n, port_direction_out;
   logic        peripheral_reset_n, port_irq, stall = 1'b0, irq_req = 1'b0;
   logic [3:0]  lag = 4'h2;
   logic        ds_seen, as_seen, wi_lo, q_oe;
   int          rdy_cnt, error_cnt = 0, n_compared = 0;

   always #10 clk = ~clk;

   eppecp_port dut (.clk, .rst, .isa_cs, .isa_addr, .isa_ior_n, .isa_iow_n, .isa_data_in,
      .isa_data_out, .isa_data_oe, .isa_iochrdy, .cfg_irq_sel, .cfg_dma_sel,
      .parallel_data_bus_in(bus_in), .parallel_data_bus_out(bus_out),
      .parallel_data_bus_oe(bus_oe), .peripheral_wait_n, .peripheral_interrupt_in, .ack_n,
      .paper_error, .select_in, .fault_n, .data_strobe_n, .address_strobe_n,
      .write_indication_n, .port_direction_out, .peripheral_reset_n, .port_irq);

   eppecp_periph u_periph (.clk, .rst, .data_strobe_n, .address_strobe_n,
      .write_indication_n, .bus_out, .bus_oe, .stall, .lag, .rd_val, .irq_req,
      .peripheral_wait_n, .bus_in, .peripheral_interrupt_in);

   // Sticky flags of what the port did during the last cycle
   always @(posedge clk) begin
      if (data_strobe_n === 1'b0) ds_seen = 1'b1;
      if (address_strobe_n === 1'b0) as_seen = 1'b1;
      if (write_indication_n === 1'b0 && data_strobe_n === 1'b0) wi_lo = 1'b1;
      if (isa_iochrdy === 1'b0) rdy_cnt++;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic clr();
      ds_seen = 1'b0;
      as_seen = 1'b0;
      wi_lo = 1'b0;
      rdy_cnt = 0;
   endtask

   // One host access; the strobe is held until ready, since there is no ack
   task automatic io(input logic wr, input logic [10:0] a, input logic [7:0] d);
      int i;
      tick(1);
      isa_cs = 1'b1;
      isa_addr = a;
      isa_data_in = d;
      isa_iow_n = ~wr;
      isa_ior_n = wr;
      tick(6);
      i = 0;
      // Ready is looked at settled, just after the edge that moves it
      while (isa_iochrdy !== 1'b1 && i < 1000) begin
         tick(1);
         i++;
      end
      if (i == 1000) error_cnt++;
      tick(2);
      q = isa_data_out;
      q_oe = isa_data_oe;
      isa_ior_n = 1'b1;
      isa_iow_n = 1'b1;
      tick(5);
      isa_cs = 1'b0;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Whole run takes about 30 us; eight times that means a hang
   initial begin
      #240000;
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      tick(2);
      rst = 1'b0;
      tick(5);
      chk({data_strobe_n, address_strobe_n, write_indication_n, port_direction_out,
           peripheral_reset_n, isa_iochrdy, port_irq, 1'b0}, 8'hEC);
      io(0, OFS_CONTROL, 8'h00);
      chk(q, 8'h04);
      done("reset");
      io(1, OFS_DATA, 8'h5A);
      chk({7'h0, q_oe}, 8'h00);
      io(0, OFS_DATA, 8'h00);
      chk(q, 8'h5A);
      chk({7'h0, q_oe}, 8'h01);
      chk(bus_out, 8'h5A);
      io(1, OFS_CONTROL, 8'h05);
      chk({7'h0, write_indication_n}, 8'h00);
      io(1, OFS_CONTROL, 8'h00);
      chk({7'h0, peripheral_reset_n}, 8'h00);
      io(1, OFS_CONTROL, 8'h24);
      chk({6'h0, port_direction_out, bus_oe}, 8'h02);
      io(0, OFS_STATUS, 8'h00);
      chk({4'h0, q[6:3]}, 8'h06);
      done("registers");
      io(1, OFS_ECR, 8'h80);
      io(0, OFS_ECR, 8'h00);
      chk({q[7:5], 3'h0, q[1:0]}, 8'h81);
      for (int k = 0; k < 2; k++) begin
         cfg_irq_sel = k ? 3'h2 : 3'h5;
         cfg_dma_sel = k ? 3'h1 : 3'h3;
         io(0, OFS_CONFIG_B_IRQ_DMA, 8'h00);
         chk({4'h0, q[6:3]}, {5'h0, cfg_irq_sel});
         chk({5'h0, q[2:0]}, {5'h0, cfg_dma_sel});
      end
      io(0, OFS_CONTROL, 8'h00);
      chk(q, 8'h24);
      done("config");
      // Address read at the low end, data read at the top data offset
      for (int k = 0; k < 2; k++) begin
         rd_val = k ? 8'hC3 : 8'hA5;
         clr();
         io(0, k ? OFS_EPP_DAT3 : OFS_EPP_ADDR, 8'h00);
         chk(q, rd_val);
         chk({6'h0, ds_seen, as_seen}, k ? 8'h02 : 8'h01);
         chk({7'h0, rdy_cnt > 0}, 8'h01);
         chk({6'h0, data_strobe_n, address_strobe_n}, 8'h03);
      end
      done("enhanced read");
      stall = 1'b1;
      clr();
      io(0, OFS_EPP_DAT0, 8'h00);
      stall = 1'b0;
      chk({7'h0, rdy_cnt == EPP_TMO_CYC}, 8'h01);
      chk({6'h0, data_strobe_n, address_strobe_n}, 8'h03);
      io(0, OFS_STATUS, 8'h00);
      chk({7'h0, q[DSR_TMO]}, 8'h01);
      io(0, OFS_STATUS, 8'h00);
      chk({7'h0, q[DSR_TMO]}, 8'h00);
      done("timeout");
      io(1, OFS_CONTROL, 8'h04);
      clr();
      io(1, OFS_EPP_DAT0, 8'h3C);
      chk(bus_out, 8'h3C);
      chk({6'h0, ds_seen, wi_lo}, 8'h03);
      chk({7'h0, write_indication_n}, 8'h01);
      done("enhanced write");
      // Enabled, then masked
      for (int k = 0; k < 2; k++) begin
         io(1, OFS_CONTROL, k ? 8'h04 : 8'h14);
         irq_req = 1'b1;
         tick(6);
         chk({7'h0, port_irq}, k ? 8'h00 : 8'h01);
         irq_req = 1'b0;
         tick(6);
         chk({7'h0, port_irq}, 8'h00);
      end
      done("interrupt");
      io(1, OFS_ECR, 8'hC0);
      for (int i = 0; i < 17; i++) io(1, OFS_FIFO, 8'(i * 17));
      io(0, OFS_ECR, 8'h00);
      chk({6'h0, q[1:0]}, 8'h02);
      for (int i = 0; i < 16; i++) begin
         io(0, OFS_FIFO, 8'h00);
         chk(q, 8'(i * 17));
      end
      io(0, OFS_ECR, 8'h00);
      chk({6'h0, q[1:0]}, 8'h01);
      // Compatibility FIFO, then address FIFO at offset 0, both into the one FIFO
      io(1, OFS_ECR, 8'h40);
      io(1, OFS_FIFO, 8'h99);
      io(1, OFS_ECR, 8'h60);
      io(1, OFS_DATA, 8'h77);
      for (int i = 0; i < 2; i++) begin
         io(0, OFS_FIFO, 8'h00);
         chk(q, i ? 8'h77 : 8'h99);
      end
      io(1, OFS_ECR, 8'hE0);
      io(0, OFS_FIFO, 8'h00);
      chk(q, CONFIG_A_FIXED_VAL);
      done("fifo");
      tally_and_finish();
   end
endmodule // tb
